// [bench/plsr_pin_drv.sv]
// pin-side model: clock, inhibit, mode, serial, parallel and clear pins
// assumes the bench calls its tasks; pins change only at falling core edges
`timescale 1ns/1ps

// -------------------------------------------------------------------
// pin driver
// -------------------------------------------------------------------
module plsr_pin_drv (
   // clock
   input  wire logic              core_clk_i,
   // register pins
   output logic                   clock_pin_o,
   output logic                   clock_gate_block_o,
   output logic                   shift_load_select_o,
   output logic                   serial_in_o,
   output logic                   direct_clear_n_o,
   output plsr_pkg::plsr_stages_t par_o
);
   import plsr_pkg::*;

   initial begin
      clock_pin_o         = 1'b1;
      clock_gate_block_o  = 1'b0;
      shift_load_select_o = SEL_SHIFT;
      serial_in_o         = 1'b0;
      direct_clear_n_o    = 1'b1;
      par_o               = 8'h00;
   end

   // one nor rising edge made by the clock pin, clear optional
   task automatic pin_edge(input logic sel, input logic serial_in, input plsr_stages_t par,
                           input logic clr_n);
      @(negedge core_clk_i);
      shift_load_select_o = sel;
      serial_in_o         = serial_in;
      par_o               = par;
      @(negedge core_clk_i);
      clock_pin_o      = 1'b0;
      direct_clear_n_o = clr_n;
      @(negedge core_clk_i);
      clock_pin_o      = 1'b1;
      direct_clear_n_o = 1'b1;
      // hold time over: data lines no longer show the old value
      serial_in_o      = ~serial_in;
      par_o            = ~par;
   endtask : pin_edge

   // clock pin parked low, inhibit pin acts as the clock
   task automatic inh_edge(input logic serial_in);
      @(negedge core_clk_i);
      clock_gate_block_o  = 1'b1;
      shift_load_select_o = SEL_SHIFT;
      serial_in_o         = serial_in;
      @(negedge core_clk_i);
      clock_pin_o = 1'b0;
      @(negedge core_clk_i);
      clock_gate_block_o = 1'b0;
      @(negedge core_clk_i);
      clock_pin_o = 1'b1;
      serial_in_o = ~serial_in;
   endtask : inh_edge

   // clock pin toggles while inhibit holds the nor low
   task automatic blocked();
      @(negedge core_clk_i) clock_gate_block_o = 1'b1;
      repeat (2) begin
         @(negedge core_clk_i) clock_pin_o = 1'b0;
         @(negedge core_clk_i) clock_pin_o = 1'b1;
      end
      @(negedge core_clk_i) clock_gate_block_o = 1'b0;
   endtask : blocked

endmodule : plsr_pin_drv

// [bench/plsr_shift_reg_test.sv]
// self-checking bench for the parallel-load shift register
// assumes plsr_pin_drv drives the pins; the bench owns the snapshot sink
`timescale 1ns/1ps

// -------------------------------------------------------------------
// bench top
// -------------------------------------------------------------------
module plsr_shift_reg_test;
   import plsr_pkg::*;

   logic         core_clk   = 1'b0;
   logic         rst_n      = 1'b0;
   logic         snap_ready = 1'b1;
   logic         clk_pin, gate_blk, sel, serial_in, clr_n, serial_out, snap_valid;
   plsr_stages_t par;
   plsr_snap_t   snap_data, last;
   int           num_errors = 0;
   int           checks_done = 0;
   int           cycles = 0;
   int           n_rec;

   always #25 core_clk = ~core_clk;

   plsr_pin_drv plsr_pin_drv_i (.core_clk_i(core_clk), .clock_pin_o(clk_pin),
      .clock_gate_block_o(gate_blk), .shift_load_select_o(sel), .serial_in_o(serial_in),
      .direct_clear_n_o(clr_n), .par_o(par));

   plsr_shift_reg plsr_shift_reg_i (.core_clk_i(core_clk), .rst_n_i(rst_n),
      .clock_pin_i(clk_pin), .clock_gate_block_i(gate_blk), .shift_load_select_i(sel),
      .serial_in_i(serial_in), .direct_clear_n_i(clr_n), .par_i(par),
      .serial_out_o(serial_out), .snap_valid_o(snap_valid), .snap_ready_i(snap_ready),
      .snap_data_o(snap_data));

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   task automatic print_verdict();
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   // a hang must still reach the verdict
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         print_verdict();
      end
   end

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // records taken by the sink over n falling edges, last one kept
   task automatic collect(input int n);
      n_rec = 0;
      repeat (n) begin
         if (snap_valid === 1'b1 && snap_ready === 1'b1) begin
            n_rec++;
            last = snap_data;
         end
         @(negedge core_clk);
      end
   endtask : collect

   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task automatic t_load_shift();
      plsr_stages_t ld  = 8'hcc;
      plsr_stages_t pat = 8'hb3;
      logic         e;
      // first and last bits differ, so a swapped input order shows
      plsr_pin_drv_i.pin_edge(SEL_LOAD, 1'b1, ld, 1'b1);
      chk({9'h0, serial_out}, {9'h0, ld[LAST_STAGE]});
      collect(6);
      chk(10'(n_rec), 10'h1);
      chk(last, {2'b01, ld});
      for (int k = 0; k < 8; k++) begin
         plsr_pin_drv_i.pin_edge(SEL_SHIFT, pat[7 - k], 8'h5a, 1'b1);
         e = (k < 7) ? ld[6 - k] : pat[7];
         chk({9'h0, serial_out}, {9'h0, e});
      end
      collect(6);
      chk(last, {2'b00, pat});
   endtask : t_load_shift

   // inhibit blocks, then inhibit pin itself clocks
   task automatic t_inhibit();
      plsr_pin_drv_i.blocked();
      collect(6);
      chk(10'(n_rec), 10'h0);
      chk({9'h0, serial_out}, 10'h1);
      plsr_pin_drv_i.inh_edge(1'b0);
      collect(6);
      chk(last, {2'b00, 8'h66});
      chk(10'(n_rec), 10'h1);
   endtask : t_inhibit

   // clear lands on the same edge as a pending load
   task automatic t_clear();
      plsr_pin_drv_i.pin_edge(SEL_LOAD, 1'b1, 8'hff, 1'b0);
      chk({9'h0, serial_out}, 10'h0);
      collect(6);
      chk({last.was_clear, 1'b0, last.stages}, 10'h200);
   endtask : t_clear

   // stalled sink: nine records fit, the tenth edge is dropped
   task automatic t_fill();
      @(negedge core_clk) snap_ready = 1'b0;
      for (int k = 0; k < 10; k++) begin
         plsr_pin_drv_i.pin_edge(SEL_SHIFT, k < 8, 8'h00, 1'b1);
      end
      snap_ready = 1'b1;
      collect(20);
      chk(10'(n_rec), 10'h9);
      chk(last, {2'b00, 8'hfe});
      plsr_pin_drv_i.pin_edge(SEL_SHIFT, 1'b1, 8'h00, 1'b1);
      collect(6);
      chk(last, {2'b00, 8'hfd});
   endtask : t_fill

   // mid-run reset wipes a loaded register; no edge may follow release
   task automatic t_reset();
      @(negedge core_clk) rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      chk({8'h0, serial_out, snap_valid}, 10'h0);
      rst_n = 1'b1;
      collect(4);
      chk(10'(n_rec), 10'h0);
      chk({9'h0, serial_out}, 10'h0);
   endtask : t_reset

   initial begin
      repeat (2) @(negedge core_clk);
      chk({8'h0, serial_out, snap_valid}, 10'h0);
      chk(snap_data, 10'h0);
      rst_n = 1'b1;
      t_load_shift();
      t_inhibit();
      t_clear();
      t_fill();
      t_reset();
      print_verdict();
   end

endmodule : plsr_shift_reg_test

// [src/plsr_pkg.sv]
// shared constants and carriers for the parallel-load shift register
// assumes a single core clock domain and synchronous active-low reset
package plsr_pkg;

   // -----------------------------------------------------------------
   // structure
   // -----------------------------------------------------------------
   localparam int unsigned STAGE_COUNT  = 8;
   localparam int unsigned SNAP_DEPTH   = 8;
   localparam int unsigned FIRST_STAGE  = 0;
   localparam int unsigned LAST_STAGE   = STAGE_COUNT - 1;

   // -----------------------------------------------------------------
   // reset values and mode select codes
   // -----------------------------------------------------------------
   localparam logic [STAGE_COUNT-1:0] STAGES_RST   = 8'h00;
   localparam logic                   NOR_PREV_RST = 1'b1;
   localparam logic                   SEL_LOAD     = 1'b0;
   localparam logic                   SEL_SHIFT    = 1'b1;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef logic [STAGE_COUNT-1:0] plsr_stages_t;

   // one record per register update, pushed into the snapshot fifo; a clear that meets a full fifo gets none
   typedef struct packed {
      logic         was_clear;
      logic         was_load;
      plsr_stages_t stages;
   } plsr_snap_t;

   localparam int unsigned SNAP_WIDTH = $bits(plsr_snap_t);

endpackage : plsr_pkg

// [src/plsr_shift_reg.sv]
// parallel-load / serial-shift eight stage register with snapshot fifo
// assumes clock, inhibit, mode, data and clear pins already synchronous
// to core_clk_i; the gated clock is sampled, not used as a clock
`timescale 1ns/1ps

// -------------------------------------------------------------------
// generic flip-flop fifo
// -------------------------------------------------------------------
module plsr_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("plsr_fifo: depth must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + AW'(1);
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   property p_no_overflow;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      count_r <= (AW+1)'(DEPTH);
   endproperty
   a_no_overflow: assert property (p_no_overflow)
      else $error("fifo count above depth");

endmodule : plsr_fifo

// -------------------------------------------------------------------
// top: shift register
// -------------------------------------------------------------------
module plsr_shift_reg #(
   parameter int unsigned STAGES = plsr_pkg::STAGE_COUNT,
   parameter int unsigned DEPTH  = plsr_pkg::SNAP_DEPTH
) (
   // clock and reset
   input  wire logic                core_clk_i,
   input  wire logic                rst_n_i,
   // register pins
   input  wire logic                clock_pin_i,
   input  wire logic                clock_gate_block_i,
   input  wire logic                shift_load_select_i,
   input  wire logic                serial_in_i,
   input  wire logic                direct_clear_n_i,
   input  wire plsr_pkg::plsr_stages_t par_i,
   output logic                     serial_out_o,
   // snapshot stream
   output logic                     snap_valid_o,
   input  wire logic                snap_ready_i,
   output plsr_pkg::plsr_snap_t     snap_data_o
);
   import plsr_pkg::*;

   initial begin
      if (STAGES != STAGE_COUNT) begin
         $error("plsr_shift_reg: only eight stages are supported");
      end
   end

   // -----------------------------------------------------------------
   // gated clock edge detect
   // -----------------------------------------------------------------
   logic         nor_now;
   logic         nor_prev_r;
   logic         edge_seen;
   logic         stall;
   logic         take_edge;
   plsr_stages_t stages_r;
   plsr_stages_t stages_nxt;

   // inhibit falling while the clock pin is low also gives a nor rising edge, as inh_edge uses
   assign nor_now   = ~(clock_pin_i | clock_gate_block_i);
   assign edge_seen = nor_now & ~nor_prev_r;
   // a full snapshot fifo swallows the edge rather than lose a record
   assign take_edge = edge_seen & ~stall;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         nor_prev_r <= NOR_PREV_RST;
      end else begin
         nor_prev_r <= nor_now;
      end
   end

   // -----------------------------------------------------------------
   // stage update
   // -----------------------------------------------------------------
   always_comb begin
      if (shift_load_select_i == SEL_LOAD) begin
         stages_nxt = par_i;
      end else begin
         stages_nxt = {stages_r[LAST_STAGE-1:FIRST_STAGE], serial_in_i};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         stages_r <= STAGES_RST;
      end else if (!direct_clear_n_i) begin
         // clear is sampled, so it acts at the next core edge, not at once
         stages_r <= STAGES_RST;
      end else if (take_edge) begin
         stages_r <= stages_nxt;
      end
   end

   assign serial_out_o = stages_r[LAST_STAGE];

   // -----------------------------------------------------------------
   // snapshot fifo and output stage
   // -----------------------------------------------------------------
   plsr_snap_t snap_in;
   logic       snap_push;
   logic       fifo_ready;
   logic       fifo_valid;
   logic       fifo_pop;
   logic [SNAP_WIDTH-1:0] fifo_data;
   logic       out_valid_r;
   plsr_snap_t out_data_r;

   assign snap_push         = take_edge | ~direct_clear_n_i;
   assign snap_in.was_clear = ~direct_clear_n_i;
   assign snap_in.was_load  = (shift_load_select_i == SEL_LOAD);
   assign snap_in.stages    = direct_clear_n_i ? stages_nxt : STAGES_RST;
   assign stall             = ~fifo_ready;
   assign fifo_pop          = fifo_valid & (~out_valid_r | snap_ready_i);

   plsr_fifo #(
      .WIDTH (SNAP_WIDTH),
      .DEPTH (DEPTH)
   ) u_snap_fifo (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (snap_push),
      .in_ready_o  (fifo_ready),
      .in_data_i   (snap_in),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         out_valid_r <= 1'b0;
         out_data_r  <= '0;
      end else if (fifo_pop) begin
         out_valid_r <= 1'b1;
         out_data_r  <= plsr_snap_t'(fifo_data);
      end else if (snap_ready_i) begin
         out_valid_r <= 1'b0;
      end
   end

   assign snap_valid_o = out_valid_r;
   assign snap_data_o  = out_data_r;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   property p_shift;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      take_edge && direct_clear_n_i && shift_load_select_i
         |=> stages_r == {$past(stages_r[LAST_STAGE-1:FIRST_STAGE]), $past(serial_in_i)};
   endproperty
   a_shift: assert property (p_shift)
      else $error("shift did not move stages");

   property p_load;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      take_edge && direct_clear_n_i && !shift_load_select_i |=> stages_r == $past(par_i);
   endproperty
   a_load: assert property (p_load)
      else $error("parallel load not captured");

   property p_serial_ignored;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      take_edge && direct_clear_n_i && !shift_load_select_i && (serial_in_i != par_i[0])
         |=> stages_r[FIRST_STAGE] != $past(serial_in_i);
   endproperty
   a_serial_ignored: assert property (p_serial_ignored)
      else $error("serial data entered during load");

   property p_hold_no_edge;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !(nor_now && !nor_prev_r) && direct_clear_n_i |=> $stable(stages_r);
   endproperty
   a_hold_no_edge: assert property (p_hold_no_edge)
      else $error("stages changed without gated clock edge");

   property p_blocked;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (clock_pin_i || clock_gate_block_i) [*2] ##0 direct_clear_n_i |=> $stable(stages_r);
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("clocking not blocked by high input");

   property p_clear;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !direct_clear_n_i |=> stages_r == STAGES_RST && !serial_out_o;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear did not zero stages");

   property p_out_last;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      take_edge && direct_clear_n_i && shift_load_select_i
         |=> serial_out_o == $past(stages_r[LAST_STAGE-1]);
   endproperty
   a_out_last: assert property (p_out_last)
      else $error("serial output not fed from seventh stage");

   property p_order;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      take_edge && direct_clear_n_i && !shift_load_select_i
         |=> serial_out_o == $past(par_i[LAST_STAGE]) && stages_r[FIRST_STAGE] == $past(par_i[0]);
   endproperty
   a_order: assert property (p_order)
      else $error("parallel input order wrong");

   property p_snap_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      snap_valid_o && !snap_ready_i |=> snap_valid_o && $stable(snap_data_o);
   endproperty
   a_snap_hold: assert property (p_snap_hold)
      else $error("snapshot record changed while stalled");

   // a dropped edge must leave the stages alone
   property p_stall_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      edge_seen && stall && direct_clear_n_i |=> $stable(stages_r);
   endproperty
   a_stall_hold: assert property (p_stall_hold)
      else $error("stages moved on a dropped edge");

   c_shift_run: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (take_edge && shift_load_select_i) ##[1:20] (take_edge && shift_load_select_i));
   c_load: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_edge && !shift_load_select_i && direct_clear_n_i);
   c_clear: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !direct_clear_n_i ##1 direct_clear_n_i);
   c_stall: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
      edge_seen && stall);
   c_inh_clock: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clock_gate_block_i ##1 (take_edge && !clock_pin_i));

endmodule : plsr_shift_reg
